// >>> core/ddr4_cmd_addr_encoder.sv
// ddr4 command and address encoder: registers pins from one command request per cycle
// assumes requests come from controller logic on clk_sys; alert pin is asynchronous
//
// Contract
// R1: drive 17-bit multiplexed row/column address bus
// R2: read/write a10 high requests auto-precharge
// R3: precharge a10 high means all banks
// R4: read/write a12 high full burst, low chop
// R5: act_n high: a16..a14 are ras cas we
// R6: drive two bank group bits per command
// R7: bg0 helps select mode register
// R8: drive two bank bits per command
// R9: bank bits help select mode register
// R10: alert watched only during command training
// R11: no write crc; alert never crc
// R12: parity output over command and address
// R13: one termination output per rank, four
// R14: x16 single die uses only bg0
// R15: one active-low chip select per rank
// R16: act_n low: activate, upper bits row
`timescale 1ns/10ps
module ddr4_cmd_addr_encoder
(
    input  wire logic                         clk_sys,
    input  wire logic                         rst,
    input  wire logic                         clk_en,
    input  wire logic                         req_valid,
    input  wire ddr4_ca_pkg::cmd_req_t        req,
    input  wire logic                         x16_single_die,
    input  wire logic [ddr4_ca_pkg::RANKS-1:0] odt_req,
    input  wire logic                         training_active,
    input  wire logic                         parity_alert_in_n,
    input  wire logic                         alert_clear,
    output ddr4_ca_pkg::ca_pins_t             pins,
    output logic [ddr4_ca_pkg::RANKS-1:0]     rank_termination_ctrl,
    output logic                              parity_error,
    output logic                              parity_error_pulse
);
    import ddr4_ca_pkg::*;

    ca_pins_t         next_pins;
    logic [RANKS-1:0] next_odt;
    logic             alert_n_sync;
    logic             alert_prev;
    logic             next_alert_prev;
    logic             alert_edge;
    logic             next_parity_error;
    logic             next_parity_error_pulse;
    train_t           tr_state;
    train_t           next_tr_state;
    logic [1:0]       bg_eff;
    logic [ADDR_W-1:0] a;
    logic             act_n;
    logic [RANKS-1:0] cs_n;
    logic [2:0]       cmd_code;
    logic             rank_hit;

    alert_sync u_alert_sync
    (
        .clk_sys (clk_sys),
        .rst     (rst),
        .clk_en  (clk_en),
        .din     (parity_alert_in_n),
        .dout    (alert_n_sync)
    );

    // one chip select per rank; deselect and idle keep all high
    always_comb
    begin
        rank_hit = req_valid && (req.op != OP_DES);
        cs_n     = CS_RST_N;
        if (rank_hit)
        begin
            case (req.rank)
                2'h0:
                begin
                    cs_n[0] = 1'b0; // R15
                end
                2'h1:
                begin
                    cs_n[1] = 1'b0; // R15
                end
                2'h2:
                begin
                    cs_n[2] = 1'b0; // R15
                end
                2'h3:
                begin
                    cs_n[3] = 1'b0; // R15
                end
                default:
                begin
                    cs_n = CS_RST_N;
                end
            endcase
        end
    end

    // ras cas we levels per command, meaningful while act_n is high
    always_comb
    begin
        case (req.op)
            OP_RD:
            begin
                cmd_code = 3'h5; // R5
            end
            OP_WR:
            begin
                cmd_code = 3'h4; // R5
            end
            OP_PRE:
            begin
                cmd_code = 3'h2; // R5
            end
            OP_MRS:
            begin
                cmd_code = 3'h0; // R5
            end
            OP_REF:
            begin
                cmd_code = 3'h1; // R5
            end
            OP_ZQC:
            begin
                cmd_code = 3'h6; // R5
            end
            default:
            begin
                cmd_code = 3'h7; // R5
            end
        endcase
    end

    // command and address encoding
    always_comb
    begin
        a      = ADDR_RST;
        act_n  = 1'b1;
        bg_eff = x16_single_die ? {1'b0, req.bank_group[0]} : req.bank_group; // R14
        if (req_valid)
        begin
            a[RAS_BIT:WE_BIT] = cmd_code; // R5
            case (req.op)
                OP_ACT:
                begin
                    act_n = 1'b0; // R16
                    a     = req.row[ADDR_W-1:0]; // R1 R16
                end
                OP_RD, OP_WR:
                begin
                    a[9:0]    = req.col; // R1
                    a[AP_BIT] = req.auto_precharge; // R2
                    a[BC_BIT] = req.full_burst; // R4
                end
                OP_PRE:
                begin
                    a[AP_BIT] = req.precharge_all; // R3
                end
                OP_MRS:
                begin
                    a[ROW_HI_BIT:0] = req.mode_data;
                end
                default:
                begin
                    act_n = 1'b1;
                end
            endcase
        end
        next_pins.mem_addr_bus         = a; // R1
        next_pins.activate_qualifier_n = act_n;
        next_pins.rank_select_n        = cs_n;
        if (req_valid && req.op == OP_MRS)
        begin
            next_pins.bank_group_sel = {1'b0, req.mode_reg[2]}; // R7
            next_pins.bank_sel       = req.mode_reg[1:0]; // R9
        end
        else
        begin
            next_pins.bank_group_sel = bg_eff; // R6
            next_pins.bank_sel       = req.bank; // R8
        end
        // even parity over act_n, bg, ba and address
        next_pins.cmd_addr_parity_out = ^{act_n, next_pins.bank_group_sel,
                                          next_pins.bank_sel, a}; // R12
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            pins.mem_addr_bus         <= ADDR_RST;
            pins.activate_qualifier_n <= 1'b1;
            pins.bank_group_sel       <= 2'h0;
            pins.bank_sel             <= 2'h0;
            pins.rank_select_n        <= CS_RST_N;
            // act_n idles high, so even parity starts high
            pins.cmd_addr_parity_out  <= 1'b1; // R12
        end
        else if (clk_en)
        begin
            pins <= next_pins;
        end
    end

    // termination request follows one cycle later
    always_comb
    begin
        next_odt = odt_req; // R13
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            rank_termination_ctrl <= ODT_RST;
        end
        else if (clk_en)
        begin
            rank_termination_ctrl <= next_odt; // R13
        end
    end

    // falling alert edge, re-armed once the pin is high again
    always_comb
    begin
        next_alert_prev = ~alert_n_sync;
        alert_edge      = ~alert_n_sync & ~alert_prev;
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            alert_prev <= 1'b0;
        end
        else if (clk_en)
        begin
            alert_prev <= next_alert_prev;
        end
    end

    // alert monitor: only during training, parity error only (no crc)
    // sticky flag; a new alert beats a clear in the same cycle
    always_comb
    begin
        next_tr_state           = tr_state;
        next_parity_error       = parity_error;
        next_parity_error_pulse = 1'b0;
        case (tr_state)
            TR_IDLE:
            begin
                next_parity_error = parity_error & ~alert_clear;
                if (training_active)
                begin
                    next_tr_state = TR_WATCH; // R10
                end
            end
            TR_WATCH:
            begin
                if (alert_clear)
                begin
                    next_parity_error = 1'b0;
                end
                if (alert_edge)
                begin
                    next_parity_error       = 1'b1; // R10 R11
                    next_parity_error_pulse = 1'b1;
                    next_tr_state           = TR_FLAG;
                end
                if (!training_active)
                begin
                    next_tr_state = TR_IDLE;
                end
            end
            TR_FLAG:
            begin
                if (alert_clear)
                begin
                    next_parity_error = 1'b0;
                end
                if (!training_active)
                begin
                    next_tr_state = TR_IDLE;
                end
                else if (alert_n_sync)
                begin
                    next_tr_state = TR_WATCH;
                end
            end
            default:
            begin
                next_tr_state = TR_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            tr_state           <= TR_IDLE;
            parity_error       <= 1'b0;
            parity_error_pulse <= 1'b0;
        end
        else if (clk_en)
        begin
            tr_state           <= next_tr_state;
            parity_error       <= next_parity_error;
            parity_error_pulse <= next_parity_error_pulse;
        end
    end
endmodule

// >>> shared/ddr4_ca_pkg.sv
// ddr4 command/address encoder package: command codes, field positions, struct types
// assumes a single controller clock domain; no software registers
package ddr4_ca_pkg;
    localparam int ADDR_W      = 17;
    localparam int RANKS       = 4;
    localparam int AP_BIT      = 10;
    localparam int BC_BIT      = 12;
    localparam int RAS_BIT     = 16;
    localparam int CAS_BIT     = 15;
    localparam int WE_BIT      = 14;
    localparam int ROW_HI_BIT  = 13;
    localparam int MR_SEL_W    = 3;
    localparam logic [ADDR_W-1:0] ADDR_RST = 17'h00000;
    localparam logic [RANKS-1:0]  CS_RST_N = 4'hf;
    localparam logic [RANKS-1:0]  ODT_RST  = 4'h0;
    localparam int SYNC_STAGES = 2;

    typedef enum logic [3:0]
    {
        OP_NOP   = 4'h0,
        OP_ACT   = 4'h1,
        OP_RD    = 4'h2,
        OP_WR    = 4'h3,
        OP_PRE   = 4'h4,
        OP_MRS   = 4'h5,
        OP_REF   = 4'h6,
        OP_ZQC   = 4'h7,
        OP_DES   = 4'h8
    } op_t;

    typedef struct packed
    {
        op_t              op;
        logic [1:0]       rank;
        logic [1:0]       bank_group;
        logic [1:0]       bank;
        logic [17:0]      row;
        logic [9:0]       col;
        logic             auto_precharge;
        logic             full_burst;
        logic             precharge_all;
        logic [MR_SEL_W-1:0] mode_reg;
        logic [13:0]      mode_data;
    } cmd_req_t;

    typedef struct packed
    {
        logic [ADDR_W-1:0] mem_addr_bus;
        logic              activate_qualifier_n;
        logic [1:0]        bank_group_sel;
        logic [1:0]        bank_sel;
        logic [RANKS-1:0]  rank_select_n;
        logic              cmd_addr_parity_out;
    } ca_pins_t;

    typedef enum logic [2:0]
    {
        TR_IDLE  = 3'b001,
        TR_WATCH = 3'b010,
        TR_FLAG  = 3'b100
    } train_t;
endpackage

// >>> core/alert_sync.sv
// two-flop synchroniser for the asynchronous alert pin
// assumes clk_sys domain, async active-high reset
`timescale 1ns/10ps
module alert_sync
(
    input  wire logic clk_sys,
    input  wire logic rst,
    input  wire logic clk_en,
    input  wire logic din,
    output logic      dout
);
    import ddr4_ca_pkg::*;
    logic [SYNC_STAGES-1:0] stage;
    logic [SYNC_STAGES-1:0] next_stage;

    always_comb
    begin
        next_stage = {stage[SYNC_STAGES-2:0], din};
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            stage <= {SYNC_STAGES{1'b1}};
        else if (clk_en)
            stage <= next_stage;
    end

    assign dout = stage[SYNC_STAGES-1];
endmodule

// >>> verification/ddr4_ca_sva.sv
// checker for the command/address encoder ports
// assumes bind onto the encoder, one clock domain
`timescale 1ns/10ps
module ddr4_ca_sva
(
    input logic                          clk_sys,
    input logic                          rst,
    input logic                          clk_en,
    input logic                          req_valid,
    input ddr4_ca_pkg::cmd_req_t         req,
    input logic                          x16_single_die,
    input logic [ddr4_ca_pkg::RANKS-1:0] odt_req,
    input logic                          training_active,
    input ddr4_ca_pkg::ca_pins_t         pins,
    input logic [ddr4_ca_pkg::RANKS-1:0] rank_termination_ctrl,
    input logic                          parity_error_pulse
);
    import ddr4_ca_pkg::*;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    sequence s_take(op_t o);
        clk_en && req_valid && req.op == o;
    endsequence
    sequence s_no_train;
        !training_active [*4];
    endsequence
    a_act_row:
    assert property (s_take(OP_ACT) |=> !pins.activate_qualifier_n
        && pins.mem_addr_bus == $past(req.row[16:0]) && pins.bank_sel == $past(req.bank))
        else $error("activate fields wrong");
    a_rd_fields:
    assert property (s_take(OP_RD) |=> pins.mem_addr_bus[16:14] == 3'h5
        && pins.mem_addr_bus[10] == $past(req.auto_precharge) && pins.mem_addr_bus[12] == $past(req.full_burst))
        else $error("read fields wrong");
    a_pre_all:
    assert property (s_take(OP_PRE) |=> pins.mem_addr_bus[16:14] == 3'h2
        && pins.mem_addr_bus[10] == $past(req.precharge_all)) else $error("precharge fields wrong");
    a_mrs_sel:
    assert property (s_take(OP_MRS) |=> {pins.bank_group_sel[0], pins.bank_sel} == $past(req.mode_reg))
        else $error("mode register select wrong");
    a_bg1_x16:
    assert property (clk_en && x16_single_die |=> !pins.bank_group_sel[1]) else $error("upper group bit used");
    a_parity_even:
    assert property (pins.cmd_addr_parity_out == ^{pins.activate_qualifier_n, pins.bank_group_sel,
        pins.bank_sel, pins.mem_addr_bus}) else $error("parity wrong");
    a_odt_follow:
    assert property (clk_en |=> rank_termination_ctrl == $past(odt_req)) else $error("termination wrong");
    a_freeze_hold:
    assert property (!clk_en |=> $stable(pins) && $stable(rank_termination_ctrl)
        && $stable(parity_error_pulse)) else $error("state moved while frozen");
    a_idle_desel:
    assert property (clk_en && !req_valid |=> pins.rank_select_n == 4'hf) else $error("rank selected idle");
    a_alert_gate:
    assert property (s_no_train |-> !parity_error_pulse) else $error("alert outside training");
endmodule

// >>> verification/sdram_alert_model.sv
// sdram side: checks command/address parity, pulls alert low
// assumes pins sampled on clk_sys; alert pulled up when released
`timescale 1ns/10ps
module sdram_alert_model
(
    input logic                  clk_sys,
    input ddr4_ca_pkg::ca_pins_t pins,
    input logic                  flip,
    output logic                 alert_n
);
    logic [2:0] hold = 3'h0;
    always @(posedge clk_sys)
    begin
        if (pins.rank_select_n != 4'hf && (flip ^ (^{pins.activate_qualifier_n, pins.bank_group_sel,
            pins.bank_sel, pins.mem_addr_bus, pins.cmd_addr_parity_out})))
            hold <= 3'h4;
        else if (hold != 3'h0)
            hold <= hold - 3'h1;
    end
    assign alert_n = (hold == 3'h0);
endmodule

// >>> verification/tb_top.sv
// self-checking bench for the command/address encoder
// assumes the alert model as sdram side, 20 MHz clock
`timescale 1ns/10ps
module tb_top;
    import ddr4_ca_pkg::*;
    typedef struct {cmd_req_t r; logic [16:0] a; logic [8:0] m;} row_t;
    logic     clk_sys, rst, clk_en, req_valid, x16_single_die, training_active, alert_clear, flip, alert_n;
    logic     err, pulse;
    logic [3:0] odt_req, odt;
    cmd_req_t req;
    ca_pins_t pins;
    int       bad_count, compares, i, k;
    row_t     rows[10];
    ddr4_cmd_addr_encoder ddr4_cmd_addr_encoder_inst (.clk_sys(clk_sys), .rst(rst), .clk_en(clk_en),
        .req_valid(req_valid), .req(req), .x16_single_die(x16_single_die), .odt_req(odt_req),
        .training_active(training_active), .parity_alert_in_n(alert_n), .alert_clear(alert_clear),
        .pins(pins), .rank_termination_ctrl(odt), .parity_error(err), .parity_error_pulse(pulse));
    sdram_alert_model sdram_alert_model_inst (.clk_sys(clk_sys), .pins(pins), .flip(flip), .alert_n(alert_n));
    function automatic cmd_req_t mk(op_t o, logic [1:0] rk, g, b, logic [17:0] rw, logic [9:0] c,
        logic [2:0] f, mr, logic [13:0] md);
        mk = '{o, rk, g, b, rw, c, f[2], f[1], f[0], mr, md};
    endfunction
    task chk(input logic [31:0] g, e);
        compares++;
        if (g !== e)
        begin
            $display("unexpected at %0t got %h exp %h", $time, g, e);
            bad_count++;
        end
    endtask
    task end_of_test;
        $display("compares %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task send(input cmd_req_t r);
        @(posedge clk_sys);
        req <= r;
        req_valid <= 1'b1;
        @(negedge clk_sys);
        @(negedge clk_sys);
    endtask
    initial
    begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end
    initial
    begin
        rows = '{'{mk(OP_ACT, 0, 2, 1, 18'h1abcd, 0, 0, 0, 0), 17'h1abcd, 9'h09e},
            '{mk(OP_RD, 1, 1, 3, 0, 10'h2a5, 3'h4, 0, 0), 17'h146a5, 9'h17d},
            '{mk(OP_WR, 2, 3, 0, 0, 10'h15a, 3'h2, 0, 0), 17'h1115a, 9'h1cb},
            '{mk(OP_PRE, 3, 0, 2, 0, 0, 3'h1, 0, 0), 17'h08400, 9'h127},
            '{mk(OP_PRE, 0, 1, 1, 0, 0, 0, 0, 0), 17'h08000, 9'h15e},
            '{mk(OP_MRS, 1, 3, 0, 0, 0, 0, 3'h6, 14'h2a55), 17'h02a55, 9'h16d},
            '{mk(OP_REF, 2, 0, 0, 0, 0, 0, 0, 0), 17'h04000, 9'h10b},
            '{mk(OP_ZQC, 3, 0, 0, 0, 0, 0, 0, 0), 17'h18000, 9'h107},
            '{mk(OP_NOP, 0, 0, 0, 0, 0, 0, 0, 0), 17'h1c000, 9'h10e},
            '{mk(OP_DES, 1, 0, 0, 0, 0, 0, 0, 0), 17'h1c000, 9'h10f}};
        {clk_en, req_valid, x16_single_die, training_active, alert_clear, flip} = 6'h20;
        req = '0;
        odt_req = 4'h0;
        bad_count = 0;
        compares = 0;
        rst = 1'b1;
        repeat (7) @(posedge clk_sys);
        @(negedge clk_sys);
        chk(pins, {17'h0, 1'b1, 4'h0, 4'hf, 1'b1});
        chk({odt, err, pulse}, 6'h0);
        @(posedge clk_sys) rst <= 1'b0;
        repeat (5) @(negedge clk_sys);
        chk(pins.rank_select_n, 4'hf);
        $display("reset test done");
        @(posedge clk_sys) training_active <= 1'b1;
        for (i = 0; i < 10; i++)
        begin
            send(rows[i].r);
            chk(pins.mem_addr_bus, rows[i].a);
            chk({pins.activate_qualifier_n, pins.bank_group_sel, pins.bank_sel, pins.rank_select_n}, rows[i].m);
            chk(pins.cmd_addr_parity_out, ^{rows[i].a, rows[i].m[8:4]});
        end
        $display("table test done");
        @(posedge clk_sys) x16_single_die <= 1'b1;
        send(mk(OP_ACT, 0, 3, 0, 0, 0, 0, 0, 0));
        chk(pins.bank_group_sel, 2'h1);
        @(posedge clk_sys) odt_req <= 4'ha;
        @(posedge clk_sys) req_valid <= 1'b0;
        @(negedge clk_sys);
        @(negedge clk_sys);
        chk({odt, pins.rank_select_n}, 8'haf);
        chk(err, 1'b0);
        $display("select test done");
        @(posedge clk_sys) x16_single_die <= 1'b0;
        send(mk(OP_NOP, 0, 0, 0, 0, 0, 0, 0, 0));
        @(posedge clk_sys) flip <= 1'b1;
        repeat (2) @(posedge clk_sys);
        flip <= 1'b0;
        for (k = 0; k < 10 && pulse !== 1'b1; k++)
            @(negedge clk_sys);
        chk(pulse, 1'b1);
        if (k == 10)
            end_of_test();
        @(negedge clk_sys);
        chk({pulse, err}, 2'h1);
        repeat (6) @(negedge clk_sys);
        chk(err, 1'b1);
        @(posedge clk_sys) alert_clear <= 1'b1;
        @(posedge clk_sys) alert_clear <= 1'b0;
        @(negedge clk_sys);
        chk(err, 1'b0);
        $display("alert test done");
        @(posedge clk_sys) {training_active, flip} <= 2'h1;
        repeat (2) @(posedge clk_sys);
        flip <= 1'b0;
        repeat (9) @(negedge clk_sys);
        chk({err, pulse}, 2'h0);
        $display("gate test done");
        @(posedge clk_sys) {clk_en, odt_req} <= 5'h05;
        send(mk(OP_RD, 2, 0, 0, 0, 10'h3ff, 3'h6, 0, 0));
        chk({odt, pins.rank_select_n, pins.mem_addr_bus}, {4'ha, 4'he, 17'h1c000});
        @(posedge clk_sys) clk_en <= 1'b1;
        @(negedge clk_sys);
        @(negedge clk_sys);
        chk({odt, pins.rank_select_n, pins.mem_addr_bus}, {4'h5, 4'hb, 17'h157ff});
        $display("freeze test done");
        end_of_test();
    end
endmodule
bind ddr4_cmd_addr_encoder ddr4_ca_sva ddr4_ca_sva_inst (.clk_sys(clk_sys), .rst(rst), .clk_en(clk_en),
    .req_valid(req_valid), .req(req), .x16_single_die(x16_single_die), .odt_req(odt_req),
    .training_active(training_active), .pins(pins), .rank_termination_ctrl(rank_termination_ctrl),
    .parity_error_pulse(parity_error_pulse));
